// ==== dv/jpeg_iap_assertions.sv ====
/*
 * Port checks of the indirect access port, bound onto jpeg_iap.
 * Assumes it sees only the top module's ports, one clock, reset active low.
 */
`timescale 1ns/1ns
module jpeg_iap_assertions
   import jpeg_iap_pkg::*;
(
   input wire logic                   core_clk,
   input wire logic                   arst_n,
   input wire jpeg_iap_pkg::reg_req_t reg_req,
   input wire logic                   sram_test_mode,
   input wire jpeg_iap_pkg::reg_rsp_t reg_rsp,
   input wire logic                   burst_mode,
   input wire logic                   burst_refused
);
   // ****************************************************************
   // Request decode
   // ****************************************************************
   // Aliases count as data accesses; the design refuses them outside a burst itself
   wire logic rd_w    = reg_req.valid && !reg_req.write;
   wire logic wr_w    = reg_req.valid && reg_req.write;
   wire logic alias_w = (reg_req.addr >= OFS_ALIAS_LO) && (reg_req.addr <= OFS_ALIAS_HI);
   wire logic data_w  = (reg_req.addr == OFS_DATA) || alias_w;
   wire logic ctrl_wr = wr_w && (reg_req.addr == OFS_CTRL);

   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_read_answered: assert property (rd_w |-> ##2 reg_rsp.valid)
      else $error("read got no answer");
   a_answer_cause: assert property (reg_rsp.valid |-> $past(rd_w, 2))
      else $error("answer without a read");
   a_write_silent: assert property (wr_w |-> ##2 !reg_rsp.valid)
      else $error("write produced an answer");
   a_idle_zero: assert property (!reg_rsp.valid |-> reg_rsp.rdata == 16'h0000)
      else $error("read data not zero between answers");
   a_burst_follows: assert property (ctrl_wr |=> burst_mode == $past(reg_req.wdata[CTRL_BURST_BIT]))
      else $error("burst mode differs from control bit");
   a_burst_steady: assert property (!ctrl_wr |=> $stable(burst_mode))
      else $error("burst mode moved without control write");
   a_refuse_in_burst: assert property (burst_refused |-> burst_mode)
      else $error("refusal outside burst mode");
   a_refuse_clears: assert property (reg_req.valid && !data_w |=> !burst_refused)
      else $error("refusal kept after other access");
   a_refused_zero: assert property (burst_refused && rd_w && data_w |-> ##2 reg_rsp.rdata == 16'h0000)
      else $error("refused read returned data");
   a_ctrl_unused: assert property (rd_w && reg_req.addr == OFS_CTRL |-> ##2 reg_rsp.rdata[12:11] == 2'b00)
      else $error("unused control bits read nonzero");
endmodule : jpeg_iap_assertions

bind jpeg_iap jpeg_iap_assertions u_chk (
   .core_clk(core_clk), .arst_n(arst_n), .reg_req(reg_req), .sram_test_mode(sram_test_mode),
   .reg_rsp(reg_rsp), .burst_mode(burst_mode), .burst_refused(burst_refused)
);

// ==== dv/reg_host.sv ====
/*
 * Model of the two-wire decoder or microcontroller driving the register port.
 * Assumes requests change on the falling edge and answers are sampled on it.
 */
`timescale 1ns/1ns
module reg_host
   import jpeg_iap_pkg::*;
(
   input  wire logic                   core_clk,
   input  wire jpeg_iap_pkg::reg_rsp_t reg_rsp,
   input  wire logic                   burst_mode,
   output jpeg_iap_pkg::reg_req_t      reg_req
);
   int beats      = 0;
   bit overrun_ok = 0;

   initial reg_req = '0;

   // ****************************************************************
   // Access tasks
   // ****************************************************************
   // Host keeps bursts within the limit; only a commanded overrun goes past it
   task automatic wr_rd(input logic w, input logic [7:0] a, input logic [15:0] d);
      logic dat;
      dat = (a == OFS_DATA) || ((a >= OFS_ALIAS_LO) && (a <= OFS_ALIAS_HI));
      @(negedge core_clk);
      beats = (dat && burst_mode) ? beats + 1 : 0;
      if (beats > int'(BURST_MAX_BEATS) && !overrun_ok) begin
         beats = beats - 1;
         reg_req.valid = 1'b0;
         return;
      end
      reg_req = '{valid: 1'b1, write: w, addr: a, wdata: d};
   endtask : wr_rd

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      wr_rd(1'b1, a, d);
   endtask : wr

   // Released lines show the inverse, never a stale copy of the last value
   task automatic idle();
      @(negedge core_clk);
      reg_req = '{valid: 1'b0, write: ~reg_req.write, addr: ~reg_req.addr, wdata: ~reg_req.wdata};
   endtask : idle

   task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
      wr_rd(1'b0, a, 16'h0000);
      idle();
      ok = 1'b0;
      d  = 16'h0000;
      for (int i = 0; i < 4 && !ok; i++) begin
         @(negedge core_clk);
         if (reg_rsp.valid === 1'b1) begin
            ok = 1'b1;
            d  = reg_rsp.rdata;
         end
      end
   endtask : rd
endmodule : reg_host

// ==== dv/test_jpeg_indirect_access_port.sv ====
/*
 * Self-checking bench of the indirect access port, random data from a fixed seed.
 * Assumes the package constants and a read answer two edges after the request is taken.
 */
`timescale 1ns/1ns
module test_jpeg_indirect_access_port;
   import jpeg_iap_pkg::*;

   logic        core_clk = 1'b0;
   logic        arst_n;
   logic        sram_test_mode;
   logic        burst_mode;
   logic        burst_refused;
   reg_req_t    reg_req;
   reg_rsp_t    reg_rsp;
   int          fail_count = 0;
   int          tests_run  = 0;
   logic [31:0] seed       = 32'hc84b9afe;
   logic [15:0] d0, d1, w0, w1, sel;
   logic [10:0] a;

   always #5 core_clk = ~core_clk;

   jpeg_iap DUT (.core_clk(core_clk), .arst_n(arst_n), .reg_req(reg_req), .sram_test_mode(sram_test_mode),
      .reg_rsp(reg_rsp), .burst_mode(burst_mode), .burst_refused(burst_refused));
   reg_host host (.core_clk(core_clk), .reg_rsp(reg_rsp), .burst_mode(burst_mode), .reg_req(reg_req));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction : rnd

   // Next SRAM word address; the last word wraps to zero
   function automatic logic [15:0] tc_next(input logic [15:0] t);
      return (t[9:0] == SRAM_LAST) ? {t[15:10], 10'h000} : t + 16'h0001;
   endfunction : tc_next

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
         fail_count++;
      end
   endtask : chk

   // A missing answer is a mismatch and ends the run
   task automatic rdc(input logic [7:0] ad, input logic [15:0] exp, input string what);
      logic [15:0] d;
      logic        ok;
      host.rd(ad, d, ok);
      if (!ok) begin
         $display("unexpected at %0t: no answer to %s", $time, what);
         fail_count++;
         test_done();
      end
      chk(d, exp, what);
   endtask : rdc

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      arst_n         = 1'b0;
      sram_test_mode = 1'b0;
      repeat (16) @(posedge core_clk);
      @(negedge core_clk) arst_n = 1'b1;
      rdc(OFS_CTRL, CTRL_RST, "ctrl reset");
      rdc(OFS_DATA, DATA_RST, "data reset");
      rdc(OFS_TEST_CTRL, TEST_CTRL_RST, "test ctrl reset");
      $display("reset test done");
      // Unused bits written as ones, burst bit kept clear
      for (int i = 0; i < 4; i++) begin
         w0 = rnd() | 16'h1800;
         w0[CTRL_BURST_BIT] = 1'b0;
         host.wr(OFS_CTRL, w0);
         rdc(OFS_CTRL, w0 & CTRL_WMASK, "ctrl readback");
      end
      for (int i = 0; i < 4; i++) begin
         a  = 11'(rnd());
         d0 = rnd();
         host.wr(OFS_CTRL, 16'h4000 | a);
         host.wr(OFS_DATA, d0);
         host.wr(OFS_CTRL, {5'h00, a});
         rdc(OFS_DATA, d0, "indirect read");
      end
      // A read-mode write must not store, but loads the addressed word
      host.wr(OFS_DATA, ~d0);
      host.wr(OFS_CTRL, 16'h4000 | a);
      rdc(OFS_DATA, d0, "write loads location");
      $display("indirect test done");
      // Auto-increment across the top of the address space
      d0 = rnd();
      d1 = rnd();
      host.wr(OFS_CTRL, 16'h47ff);
      host.wr(OFS_DATA, d0);
      host.wr(OFS_CTRL, 16'h4000);
      host.wr(OFS_DATA, d1);
      host.wr(OFS_CTRL, 16'h87ff);
      rdc(OFS_DATA, d0, "ainc first");
      rdc(OFS_DATA, d1, "ainc wrapped");
      rdc(OFS_CTRL, 16'h8001, "ainc address");
      host.wr(OFS_CTRL, 16'hc7ff);
      host.wr(OFS_DATA, ~d0);
      host.wr(OFS_CTRL, 16'h07ff);
      rdc(OFS_DATA, d0, "no store with ainc");
      $display("auto increment test done");
      // Burst: alias behaves as data port, then two accesses past the limit
      host.wr(OFS_CTRL, 16'h27ff);
      host.idle();
      chk({15'h0000, burst_mode}, 16'h0001, "burst mode on");
      rdc(8'h25, d0, "alias read");
      host.wr(OFS_CTRL, 16'h67ff);
      for (int i = 0; i < int'(BURST_MAX_BEATS); i++) host.wr(i[0] ? OFS_DATA : OFS_ALIAS_HI, d1);
      host.idle();
      chk({15'h0000, burst_refused}, 16'h0000, "full burst accepted");
      host.overrun_ok = 1'b1;
      rdc(OFS_DATA, 16'h0000, "refused read");
      chk({15'h0000, burst_refused}, 16'h0001, "overrun flagged");
      rdc(OFS_ALIAS_LO, 16'h0000, "refused again");
      host.overrun_ok = 1'b0;
      host.wr(OFS_CTRL, 16'h0000);
      host.idle();
      chk({14'h0000, burst_mode, burst_refused}, 16'h0000, "burst off");
      rdc(8'h25, 16'h0000, "alias outside burst");
      $display("burst test done");
      // SRAM test: two words written to all RAMs, read back from every one
      sram_test_mode = 1'b1;
      w0 = rnd();
      w1 = rnd();
      host.wr(OFS_TEST_CTRL, 16'h8000 | 16'd798);
      host.wr(OFS_DATA, w0);
      host.wr(OFS_DATA, w1);
      rdc(OFS_TEST_CTRL, tc_next(tc_next(16'h8000 | 16'd798)), "test write advance");
      for (int i = 0; i <= int'(SRAM_IDX_OBUF); i++) begin
         sel = (i == int'(SRAM_IDX_OBUF)) ? 16'h4000 : 16'(i << TC_IDX_LSB);
         host.wr(OFS_TEST_CTRL, sel | 16'd798);
         rdc(OFS_TEST_CTRL, sel | 16'd798, "no cycle on test ctrl");
         rdc(OFS_DATA, w0, "sram word 798");
         rdc(OFS_DATA, w1, "sram word 799");
         rdc(OFS_TEST_CTRL, tc_next(tc_next(sel | 16'd798)), "test read advance");
      end
      host.idle();
      sram_test_mode = 1'b0;
      host.wr(OFS_CTRL, 16'h07ff);
      rdc(OFS_DATA, d1, "indirect space again");
      $display("sram test done");
      test_done();
   end
endmodule : test_jpeg_indirect_access_port

// ==== src/jpeg_iap.sv ====
/*
 * Indirect access port of the JPEG encoder: control, data and SRAM test control registers,
 * the indirect register space and the line SRAM test path.
 * Assumes the two-wire decoder or microcontroller presents one register access per cycle,
 * synchronous to core_clk, and that the SRAM test-mode bit comes from elsewhere as a level.
 */
// Overview of operation
// - Test write with write-enable set copies port value into all seventeen line SRAMs.
// - With write-enable clear, a data port access reads the selected SRAM into the port.
// - Test cycles start only on data port access, never on test control writes.
// - Indirect target address is bits 10:0 of the control register.
// - Burst bit set puts the two-wire decoder in burst mode for the data port.
// - A burst is at most 128 data port accesses; further ones are refused and flagged.
// - Indirect-write set stores data at the indirect address unless auto-increment is on.
// - Indirect-write clear makes a data port access read the indirect address.
// - Auto-increment adds one to the indirect address after each accepted data port access in test-mode 0.
// - Data port accesses act like direct accesses to the addressed location.
// - Auto-increment makes successive accesses one burst over consecutive locations.
// - Test-mode 0 targets indirect registers; test-mode 1 targets the line SRAMs.
// - Control and data registers reset to zero.
// - SRAM word address 0..799 advances after every test write or test read.
// - Three bits pick one of eight SRAMs; one bit picks luminance or chrominance.
// - During a burst, registers 0x20..0x2e behave as the data port.
`timescale 1ns/1ns
module jpeg_iap
   import jpeg_iap_pkg::*;
(
   input  wire logic                 core_clk,
   input  wire logic                 arst_n,
   input  wire jpeg_iap_pkg::reg_req_t reg_req,
   input  wire logic                 sram_test_mode,
   output jpeg_iap_pkg::reg_rsp_t    reg_rsp,
   output logic                      burst_mode,
   output logic                      burst_refused
);
   import jpeg_iap_pkg::*;

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [15:0]        ctrl_r,      ctrl_nxt;
   logic [15:0]        tc_r,        tc_nxt;
   logic [15:0]        data_r,      data_nxt;
   logic [7:0]         beat_r,      beat_nxt;
   logic               refused_r,   refused_nxt;
   logic [15:0]        early_r,     early_nxt;
   rd_src_t            src_r,       src_nxt;
   reg_rsp_t           rsp_r,       rsp_nxt;
   logic               rd_pend_r;   // Any read taken at the last edge; answers zero when it has no source
   logic               ld_ind_r;    // Indirect word lands in the data register next edge
   logic               ld_sram_r;   // Line SRAM word lands in the data register next edge

   // Memory read data
   logic [15:0]        ind_rdata;
   logic [15:0]        sram_rdata;

   // ****************************************************************
   // Control fields
   // ****************************************************************
   wire logic [IND_AW-1:0]  ind_addr  = ctrl_r[CTRL_ADDR_MSB:0];
   wire logic               burst_on  = ctrl_r[CTRL_BURST_BIT];
   wire logic               iwr_on    = ctrl_r[CTRL_IWR_BIT];
   wire logic               ainc_on   = ctrl_r[CTRL_AINC_BIT];
   wire logic [SRAM_AW-1:0] sram_addr = tc_r[TC_ADDR_MSB:0];
   wire logic               sram_we   = tc_r[TC_WE_BIT];

   // Which of the seventeen RAMs a test read uses
   wire logic [2:0]         sram_idx  = tc_r[TC_IDX_MSB:TC_IDX_LSB];
   wire logic [4:0]         sram_sel  = tc_r[TC_OBUF_BIT] ? SRAM_IDX_OBUF
                                       : {1'b0, tc_r[TC_YBANK_BIT], sram_idx};

   // ****************************************************************
   // Address decode
   // ****************************************************************
   wire logic is_rd      = reg_req.valid && !reg_req.write;
   wire logic is_wr      = reg_req.valid && reg_req.write;
   wire logic hit_ctrl   = reg_req.valid && (reg_req.addr == OFS_CTRL);
   wire logic hit_tc     = reg_req.valid && (reg_req.addr == OFS_TEST_CTRL);
   wire logic in_alias   = (reg_req.addr >= OFS_ALIAS_LO) && (reg_req.addr <= OFS_ALIAS_HI);
   wire logic hit_alias  = reg_req.valid && burst_on && in_alias;
   wire logic hit_data   = (reg_req.valid && (reg_req.addr == OFS_DATA)) || hit_alias;

   // A burst that has used all its beats refuses further data port accesses
   wire logic burst_full = burst_on && (beat_r == BURST_MAX_BEATS);
   wire logic data_acc   = hit_data && !burst_full;
   wire logic other_acc  = reg_req.valid && !hit_data;

   // ****************************************************************
   // Access routing: indirect space or line SRAMs
   // ****************************************************************
   wire logic ind_acc    = data_acc && !sram_test_mode;
   wire logic sram_acc   = data_acc && sram_test_mode;

   // Indirect write is suppressed while auto-increment is on
   wire logic ind_we     = ind_acc && is_wr && iwr_on && !ainc_on;
   wire logic ind_re     = ind_acc && !iwr_on;

   // Test write goes to all RAMs; a read access writes back the held data value
   wire logic        sram_wr_all = sram_acc && sram_we;
   wire logic        sram_re     = sram_acc && !sram_we;
   wire logic [15:0] sram_wdata  = is_wr ? reg_req.wdata : data_r;

   // Address steps taken after each access
   wire logic               ind_step   = ind_acc && ainc_on;
   wire logic [IND_AW-1:0]  ind_next   = ind_addr + 11'h001;
   wire logic [SRAM_AW-1:0] sram_next  = (sram_addr == SRAM_LAST) ? 10'h000
                                        : sram_addr + 10'h001;

   // ****************************************************************
   // Control register next value
   // ****************************************************************
   // Bus write wins over the increment: software sets the address it wants
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (hit_ctrl && is_wr) begin
         ctrl_nxt = reg_req.wdata & CTRL_WMASK;
      end else if (ind_step) begin
         ctrl_nxt = {ctrl_r[15:IND_AW], ind_next};
      end
   end

   // ****************************************************************
   // SRAM test control next value
   // ****************************************************************
   // A write here only changes settings; no RAM cycle is started
   always_comb begin
      tc_nxt = tc_r;
      if (hit_tc && is_wr) begin
         tc_nxt = reg_req.wdata;
      end else if (sram_acc) begin
         tc_nxt = {tc_r[15:SRAM_AW], sram_next};
      end
   end

   // ****************************************************************
   // Data register next value
   // ****************************************************************
   // A bus write in the same cycle as an earlier read's load is the newer value, so it wins
   // Writes count as accesses too, so a read-mode write also loads the addressed word
   always_comb begin
      data_nxt = data_r;
      if (data_acc && is_wr) begin
         data_nxt = reg_req.wdata;
      end else if (ld_ind_r) begin
         data_nxt = ind_rdata;
      end else if (ld_sram_r) begin
         data_nxt = sram_rdata;
      end
   end

   // ****************************************************************
   // Burst beat counting
   // ****************************************************************
   // Any other register access or a cleared burst bit ends the burst
   always_comb begin
      beat_nxt    = beat_r;
      refused_nxt = refused_r;
      if (!burst_on || other_acc) begin
         beat_nxt    = 8'h00;
         refused_nxt = 1'b0;
      end else if (hit_data && burst_full) begin
         refused_nxt = 1'b1;
      end else if (data_acc) begin
         beat_nxt = beat_r + 8'h01;
      end
   end

   // ****************************************************************
   // Read answer, first stage: pick the source
   // ****************************************************************
   // Memory data arrive a cycle later, so only their source is noted here
   always_comb begin
      src_nxt   = SRC_NONE;
      early_nxt = 16'h0000;
      if (is_rd) begin
         if (hit_ctrl) begin
            src_nxt   = SRC_CTRL;
            early_nxt = ctrl_r;
         end else if (hit_tc) begin
            src_nxt   = SRC_TC;
            early_nxt = tc_r;
         end else if (sram_re) begin
            src_nxt   = SRC_SRAM;
         end else if (ind_re) begin
            src_nxt   = SRC_IND;
         end else if (data_acc) begin
            src_nxt   = SRC_DATA;
            early_nxt = data_r;
         end else begin
            src_nxt   = SRC_NONE;   // Unmapped or refused reads answer zero
         end
      end
   end

   // ****************************************************************
   // Read answer, second stage: drive the response
   // ****************************************************************
   always_comb begin
      rsp_nxt.valid = 1'b0;
      rsp_nxt.rdata = 16'h0000;
      case (src_r)
         SRC_NONE: begin
            rsp_nxt.valid = rd_pend_r;
            rsp_nxt.rdata = 16'h0000;
         end
         SRC_CTRL, SRC_TC, SRC_DATA: begin
            rsp_nxt.valid = 1'b1;
            rsp_nxt.rdata = early_r;
         end
         SRC_IND: begin
            rsp_nxt.valid = 1'b1;
            rsp_nxt.rdata = ind_rdata;
         end
         SRC_SRAM: begin
            rsp_nxt.valid = 1'b1;
            rsp_nxt.rdata = sram_rdata;
         end
         default: begin
            rsp_nxt.valid = 1'b0;
            rsp_nxt.rdata = 16'h0000;
         end
      endcase
   end

   // ****************************************************************
   // Flip-flops
   // ****************************************************************
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r    <= CTRL_RST;
         tc_r      <= TEST_CTRL_RST;
         data_r    <= DATA_RST;
         beat_r    <= 8'h00;
         refused_r <= 1'b0;
      end else begin
         ctrl_r    <= ctrl_nxt;
         tc_r      <= tc_nxt;
         data_r    <= data_nxt;
         beat_r    <= beat_nxt;
         refused_r <= refused_nxt;
      end
   end

   // Answer pipeline
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         src_r     <= SRC_NONE;
         early_r   <= 16'h0000;
         rd_pend_r <= 1'b0;
         rsp_r     <= '0;
      end else begin
         src_r     <= src_nxt;
         early_r   <= early_nxt;
         rd_pend_r <= is_rd;
         rsp_r     <= rsp_nxt;
      end
   end

   // Load strobes trail each RAM read by one edge, when its registered output is valid
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ld_ind_r  <= 1'b0;
         ld_sram_r <= 1'b0;
      end else begin
         ld_ind_r  <= ind_re;
         ld_sram_r <= sram_re;
      end
   end

   // ****************************************************************
   // Memories
   // ****************************************************************
   // Indirect register and memory space, 2048 words
   sp_ram #(.WIDTH(16), .DEPTH(IND_DEPTH), .AW(IND_AW)) u_ind_space (
      .core_clk (core_clk),
      .we       (ind_we),
      .re       (ind_re),
      .addr     (ind_addr),
      .wdata    (reg_req.wdata),
      .rdata    (ind_rdata)
   );

   // The line SRAMs under test
   line_sram_bank u_line_sram (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .we_all   (sram_wr_all),
      .re       (sram_re),
      .sel      (sram_sel),
      .addr     (sram_addr),
      .wdata    (sram_wdata),
      .rdata    (sram_rdata)
   );

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign reg_rsp       = rsp_r;
   assign burst_mode    = ctrl_r[CTRL_BURST_BIT];
   assign burst_refused = refused_r;

endmodule : jpeg_iap

// ==== src/jpeg_iap_pkg.sv ====
/*
 * Constants, field layouts and carrier types for the JPEG indirect access port.
 * Assumes a 16-bit register port with 8-bit register numbers, one access per cycle.
 */
package jpeg_iap_pkg;

   // ****************************************************************
   // Register numbers on the register port
   // ****************************************************************
   localparam logic [7:0]  OFS_TEST_CTRL   = 8'h1d;
   localparam logic [7:0]  OFS_CTRL        = 8'h1e;
   localparam logic [7:0]  OFS_DATA        = 8'h1f;
   localparam logic [7:0]  OFS_ALIAS_LO    = 8'h20;
   localparam logic [7:0]  OFS_ALIAS_HI    = 8'h2e;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int          CTRL_ADDR_MSB   = 10;
   localparam int          CTRL_BURST_BIT  = 13;
   localparam int          CTRL_IWR_BIT    = 14;
   localparam int          CTRL_AINC_BIT   = 15;
   localparam logic [15:0] CTRL_WMASK      = 16'he7ff;
   localparam int          TC_ADDR_MSB     = 9;
   localparam int          TC_IDX_LSB      = 10;
   localparam int          TC_IDX_MSB      = 12;
   localparam int          TC_YBANK_BIT    = 13;
   localparam int          TC_OBUF_BIT     = 14;
   localparam int          TC_WE_BIT       = 15;
   localparam logic [15:0] CTRL_RST        = 16'h0000;
   localparam logic [15:0] TEST_CTRL_RST   = 16'h0000;
   localparam logic [15:0] DATA_RST        = 16'h0000;

   // ****************************************************************
   // Memory sizes, bank indices and burst limit
   // ****************************************************************
   localparam int          SRAM_COUNT      = 17;
   localparam int          SRAM_DEPTH      = 800;
   localparam int          SRAM_AW         = 10;
   localparam logic [9:0]  SRAM_LAST       = 10'h31f;
   localparam int          IND_DEPTH       = 2048;
   localparam int          IND_AW          = 11;
   localparam logic [4:0]  SRAM_IDX_OBUF   = 5'h10;
   localparam logic [7:0]  BURST_MAX_BEATS = 8'h80;

   // Source of a pending read answer, one-hot
   typedef enum logic [5:0] {
      SRC_NONE  = 6'b000001,
      SRC_CTRL  = 6'b000010,
      SRC_TC    = 6'b000100,
      SRC_DATA  = 6'b001000,
      SRC_IND   = 6'b010000,
      SRC_SRAM  = 6'b100000
   } rd_src_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] rdata;
   } reg_rsp_t;

endpackage : jpeg_iap_pkg

// ==== src/line_sram_bank.sv ====
/*
 * The seventeen 800x16 line SRAMs: eight luminance, eight chrominance, one output buffer.
 * Assumes one test access per cycle from the indirect access port.
 */
`timescale 1ns/1ns
module line_sram_bank
   import jpeg_iap_pkg::*;
(
   input  wire logic               core_clk,
   input  wire logic               arst_n,
   input  wire logic               we_all,
   input  wire logic               re,
   input  wire logic [4:0]         sel,
   input  wire logic [SRAM_AW-1:0] addr,
   input  wire logic [15:0]        wdata,
   output logic      [15:0]        rdata
);
   import jpeg_iap_pkg::*;

   logic [15:0] rd_all [SRAM_COUNT];
   logic [4:0]  sel_r;

   // ****************************************************************
   // One RAM per line buffer; a test write lands in all of them at once
   // ****************************************************************
   for (genvar g = 0; g < SRAM_COUNT; g++) begin : g_ram
      wire logic re_g = re && (sel == 5'(g));
      sp_ram #(.WIDTH(16), .DEPTH(SRAM_DEPTH), .AW(SRAM_AW)) u_ram (
         .core_clk (core_clk),
         .we       (we_all),
         .re       (re_g),
         .addr     (addr),
         .wdata    (wdata),
         .rdata    (rd_all[g])
      );
   end

   // Remember which RAM answered so the mux lines up with its read register
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sel_r <= 5'h00;
      end else if (re) begin
         sel_r <= sel;
      end
   end

   assign rdata = rd_all[sel_r];

endmodule : line_sram_bank

// ==== src/sp_ram.sv ====
/*
 * Single-port RAM with registered read data.
 * Assumes the caller keeps the address below the depth.
 */
`timescale 1ns/1ns
module sp_ram #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 800,
   parameter int AW    = 10
) (
   input  wire logic             core_clk,
   input  wire logic             we,
   input  wire logic             re,
   input  wire logic [AW-1:0]    addr,
   input  wire logic [WIDTH-1:0] wdata,
   output logic      [WIDTH-1:0] rdata
);

   logic [WIDTH-1:0] mem [DEPTH];

   // Storage has no reset; only the read register matters after a read
   always_ff @(posedge core_clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      if (re) begin
         rdata <= mem[addr];
      end
   end

endmodule : sp_ram
